// ===== src/bank_map_pkg.sv
// Package with the register map, reset values and address ranges of the bank mapper.
package bank_map_pkg;
   // Register indices; byte address on APB is four times the index.
   localparam logic [9:0] IDX_IBANK_LO = 10'h030;
   localparam logic [9:0] IDX_IBANK_HI = 10'h031;
   localparam logic [9:0] IDX_SYSCTL = 10'h032;
   localparam logic [9:0] IDX_PBANK = 10'h040;
   localparam logic [9:0] IDX_SBANK = 10'h041;
   localparam logic [9:0] IDX_DBANK = 10'h042;
   localparam logic [9:0] IDX_FB_END = 10'h043;
   localparam logic [9:0] IDX_STATUS = 10'h044;
   // Field layout of a bank register.
   localparam int BANK_W = 12;
   localparam int RAM_SEL_BIT = 15;
   localparam logic [15:0] BANK_MASK = 16'h8FFF;
   // System control: bit 1 enables the interrupt bank, bit 0 reads high.
   localparam int IBANK_EN_BIT = 1;
   localparam logic [7:0] SYSCTL_RST = 8'h01;
   localparam logic [7:0] SYSCTL_WMASK = 8'hFE;
   localparam logic [15:0] BANK_RST = 16'h0000;
   // Logical address map of the CPU.
   localparam logic [15:0] IO_END = 16'h007F;
   localparam logic [15:0] ZP_START = 16'h0080;
   localparam logic [15:0] STACK_START = 16'h0100;
   localparam logic [15:0] STACK_END = 16'h01FF;
   localparam logic [15:0] FB_START = 16'h0200;
   localparam logic [15:0] SWIN_START = 16'h2000;
   localparam logic [15:0] PWIN_START = 16'h4000;
   localparam logic [15:0] DWIN_START = 16'h8000;
   localparam logic [14:0] FB_END_RST = 15'h7FFF;
   // Window selector codes.
   localparam logic [1:0] WIN_DIRECT = 2'h0;
   localparam logic [1:0] WIN_SEC = 2'h1;
   localparam logic [1:0] WIN_PROG = 2'h2;
   localparam logic [1:0] WIN_DATA = 2'h3;
   typedef enum logic [1:0] {
      MODE_PROG = 2'b01,
      MODE_IRQ = 2'b10
   } bank_mode_t;
endpackage

// ===== src/frame_ram.sv
// Internal RAM with a CPU read/write port and an independent display read port.
`timescale 1ns/1ps
module frame_ram #(
   parameter int AW = 15,
   parameter int DW = 8
) (
   input wire logic clk,
   input wire logic a_en,
   input wire logic a_we,
   input wire logic [AW-1:0] a_addr,
   input wire logic [DW-1:0] a_wdata,
   output logic [DW-1:0] a_rdata,
   input wire logic b_en,
   input wire logic [AW-1:0] b_addr,
   output logic [DW-1:0] b_rdata
);
   logic [DW-1:0] mem [0:(1<<AW)-1];

   // A second read port lets the display fetch never steal a CPU cycle.
   always_ff @(posedge clk) begin
      if (a_en && a_we) begin
         mem[a_addr] <= a_wdata;
      end
      if (a_en) begin
         a_rdata <= mem[a_addr];
      end
   end

   always_ff @(posedge clk) begin
      if (b_en) begin
         b_rdata <= mem[b_addr];
      end
   end
endmodule // frame_ram

// ===== src/bank_map.sv
// Bank mapper: interrupt bank substitution, window decode, internal RAM and display fetch.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
module bank_map
   import bank_map_pkg::*;
#(
   parameter int RAM_AW = 15
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [3:0] PSTRB,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic CPU_REQ,
   input wire logic CPU_WE,
   input wire logic [15:0] CPU_ADDR,
   input wire logic [7:0] CPU_WDATA,
   input wire logic INT_TAKE,
   input wire logic RTI_DONE,
   output logic [7:0] CPU_RDATA,
   output logic CPU_ACK,
   output logic EXT_REQ,
   output logic EXT_WE,
   output logic [26:0] EXT_ADDR,
   output logic [7:0] EXT_WDATA,
   output logic IBANK_ACTIVE,
   input wire logic LCD_REQ,
   output logic [7:0] LCD_DATA,
   output logic LCD_VALID
);
   import bank_map_pkg::*;

   generate
      if (RAM_AW != 15) begin : g_bad_aw
         $error("bank_map needs a 15-bit internal RAM address");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Register file.
   logic [15:0] ibank_q;
   logic [7:0] sysctl_q;
   logic [15:0] pbank_q;
   logic [15:0] sbank_q;
   logic [15:0] dbank_q;
   logic [14:0] fb_end_q;
   bank_mode_t mode_q;
   bank_mode_t mode_d;
   logic [15:0] active_bank;
   logic [9:0] idx;
   logic mapped;
   logic wr_acc;
   logic [31:0] rd_val;
   logic [15:0] wr16;

   assign idx = PADDR[11:2];
   assign wr_acc = PSEL && PENABLE && PWRITE && mapped;
   assign wr16 = (PWDATA[15:0] & BANK_MASK);

   always_comb begin
      mapped = (PADDR[1:0] == 2'h0);
      rd_val = 32'h0000_0000;
      case (idx)
         IDX_IBANK_LO: rd_val = {24'h00_0000, ibank_q[7:0]};
         IDX_IBANK_HI: rd_val = {24'h00_0000, ibank_q[15:8]};
         IDX_SYSCTL: rd_val = {24'h00_0000, sysctl_q};
         IDX_PBANK: rd_val = {16'h0000, pbank_q};
         IDX_SBANK: rd_val = {16'h0000, sbank_q};
         IDX_DBANK: rd_val = {16'h0000, dbank_q};
         IDX_FB_END: rd_val = {17'h0_0000, fb_end_q};
         IDX_STATUS: rd_val = {15'h0000, (mode_q == MODE_IRQ), active_bank};
         default: mapped = 1'b0;
      endcase
      if (idx == IDX_STATUS && PWRITE) begin
         mapped = 1'b0;
      end
   end

   // Interrupt bank: twelve bank bits plus the internal RAM select bit.
   always_ff @(posedge CLK) begin
      if (RST) begin
         ibank_q <= BANK_RST;
      end else if (wr_acc && PSTRB[0]) begin
         if (idx == IDX_IBANK_LO) begin
            ibank_q[7:0] <= PWDATA[7:0];
         end else if (idx == IDX_IBANK_HI) begin
            ibank_q[15:8] <= PWDATA[7:0] & BANK_MASK[15:8];
         end
      end
   end

   // Bit 0 always reads high; its write meaning has no effect in this block.
   always_ff @(posedge CLK) begin
      if (RST) begin
         sysctl_q <= SYSCTL_RST;
      end else if (wr_acc && PSTRB[0] && idx == IDX_SYSCTL) begin
         sysctl_q <= (PWDATA[7:0] & SYSCTL_WMASK) | SYSCTL_RST;
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         pbank_q <= BANK_RST;
         sbank_q <= BANK_RST;
         dbank_q <= BANK_RST;
         fb_end_q <= FB_END_RST;
      end else if (wr_acc && PSTRB[1:0] == 2'h3) begin
         case (idx)
            IDX_PBANK: pbank_q <= wr16;
            IDX_SBANK: sbank_q <= wr16;
            IDX_DBANK: dbank_q <= wr16;
            IDX_FB_END: fb_end_q <= PWDATA[14:0];
            default: ;
         endcase
      end
   end

   // Read data and error are prepared in the setup phase so the access phase
   // completes at once with registered outputs.
   always_ff @(posedge CLK) begin
      if (RST) begin
         PRDATA <= 32'h0000_0000;
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
      end else begin
         PREADY <= 1'b1;
         if (PSEL && !PENABLE) begin
            PRDATA <= PWRITE ? 32'h0000_0000 : rd_val;
            PSLVERR <= !mapped;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bank mode: program bank or interrupt bank on the program window.

   always_comb begin
      mode_d = mode_q;
      case (mode_q)
         MODE_PROG: begin
            if (INT_TAKE && sysctl_q[IBANK_EN_BIT]) begin
               mode_d = MODE_IRQ;
            end
         end
         MODE_IRQ: begin
            // A new interrupt in the return cycle keeps the interrupt bank.
            if (RTI_DONE && !INT_TAKE) begin
               mode_d = MODE_PROG;
            end
         end
         default: mode_d = MODE_PROG;
      endcase
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         mode_q <= MODE_PROG;
      end else begin
         mode_q <= mode_d;
      end
   end

   // The program bank register itself is never touched, so it is restored
   // simply by leaving the interrupt mode.
   assign active_bank = (mode_q == MODE_IRQ) ? ibank_q : pbank_q;

   always_ff @(posedge CLK) begin
      if (RST) begin
         IBANK_ACTIVE <= 1'b0;
      end else begin
         IBANK_ACTIVE <= (mode_d == MODE_IRQ);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Window decode of CPU accesses.
   logic [1:0] win;
   logic [15:0] win_bank;
   logic to_ram;
   logic to_ext;

   always_comb begin
      if (CPU_ADDR >= DWIN_START) begin
         win = WIN_DATA;
      end else if (CPU_ADDR >= PWIN_START) begin
         win = WIN_PROG;
      end else if (CPU_ADDR >= SWIN_START) begin
         win = WIN_SEC;
      end else begin
         win = WIN_DIRECT;
      end
      case (win)
         WIN_SEC: win_bank = sbank_q;
         WIN_PROG: win_bank = active_bank;
         WIN_DATA: win_bank = dbank_q;
         default: win_bank = BANK_RST;
      endcase
      // Direct space covers zero page, stack and low user memory; I/O is not ours.
      to_ram = CPU_REQ && ((win == WIN_DIRECT && CPU_ADDR > IO_END) ||
                           (win != WIN_DIRECT && win_bank[RAM_SEL_BIT]));
      to_ext = CPU_REQ && win != WIN_DIRECT && !win_bank[RAM_SEL_BIT];
   end

   // Each window keeps its own place in RAM, so offset bits pass straight through:
   // secondary reaches 2000-3FFF, program 4000-7FFF, data all of 0000-7FFF.
   logic [RAM_AW-1:0] ram_addr;
   assign ram_addr = CPU_ADDR[RAM_AW-1:0];

   always_ff @(posedge CLK) begin
      if (RST) begin
         CPU_ACK <= 1'b0;
         EXT_REQ <= 1'b0;
         EXT_WE <= 1'b0;
         EXT_ADDR <= 27'h000_0000;
         EXT_WDATA <= 8'h00;
      end else begin
         CPU_ACK <= to_ram;
         EXT_REQ <= to_ext;
         if (to_ext) begin
            EXT_WE <= CPU_WE;
            EXT_ADDR <= {win_bank[BANK_W-1:0], CPU_ADDR[14:0]};
            EXT_WDATA <= CPU_WDATA;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Display fetch walks the frame buffer from its base to the set extent.
   logic [14:0] fb_ptr_q;
   logic lcd_rd_q;
   logic [7:0] ram_a_rdata;
   logic [7:0] ram_b_rdata;

   always_ff @(posedge CLK) begin
      if (RST) begin
         fb_ptr_q <= FB_START[14:0];
         lcd_rd_q <= 1'b0;
      end else begin
         lcd_rd_q <= LCD_REQ;
         if (LCD_REQ) begin
            fb_ptr_q <= (fb_ptr_q >= fb_end_q) ? FB_START[14:0] : fb_ptr_q + 15'h0001;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         LCD_VALID <= 1'b0;
         LCD_DATA <= 8'h00;
         CPU_RDATA <= 8'h00;
      end else begin
         LCD_VALID <= lcd_rd_q;
         if (lcd_rd_q) begin
            LCD_DATA <= ram_b_rdata;
         end
         if (CPU_ACK) begin
            CPU_RDATA <= ram_a_rdata;
         end
      end
   end

   frame_ram #(
      .AW(RAM_AW),
      .DW(8)
   ) u_ram (
      .clk(CLK),
      .a_en(to_ram),
      .a_we(CPU_WE),
      .a_addr(ram_addr),
      .a_wdata(CPU_WDATA),
      .a_rdata(ram_a_rdata),
      .b_en(LCD_REQ),
      .b_addr(fb_ptr_q),
      .b_rdata(ram_b_rdata)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Checks.
   sequence s_take_enabled;
      INT_TAKE && sysctl_q[IBANK_EN_BIT];
   endsequence

   sequence s_return;
      RTI_DONE && !INT_TAKE;
   endsequence

   a_take_switch: assert property (@(posedge CLK) disable iff (RST)
      s_take_enabled |=> (mode_q == MODE_IRQ) && active_bank == ibank_q)
      else $error("interrupt bank not active after take");

   a_take_disabled: assert property (@(posedge CLK) disable iff (RST)
      (mode_q == MODE_PROG && !(INT_TAKE && sysctl_q[IBANK_EN_BIT])) |=> mode_q == MODE_PROG)
      else $error("interrupt bank entered while disabled");

   a_hold_till_ret: assert property (@(posedge CLK) disable iff (RST)
      (mode_q == MODE_IRQ && !RTI_DONE) |=> mode_q == MODE_IRQ)
      else $error("interrupt bank left before return");

   a_return_restore: assert property (@(posedge CLK) disable iff (RST)
      (mode_q == MODE_IRQ) ##0 s_return |=> active_bank == pbank_q)
      else $error("program bank not restored after return");

   a_vector_window: assert property (@(posedge CLK) disable iff (RST)
      (to_ext && CPU_ADDR >= PWIN_START && CPU_ADDR < DWIN_START) |=>
         EXT_REQ && EXT_ADDR[26:15] == $past(active_bank[BANK_W-1:0]))
      else $error("program window used wrong bank");

   a_disabled_prog: assert property (@(posedge CLK) disable iff (RST)
      (INT_TAKE && !sysctl_q[IBANK_EN_BIT] && mode_q == MODE_PROG) |=>
         mode_q == MODE_PROG && !IBANK_ACTIVE && active_bank == pbank_q)
      else $error("program bank not used while interrupt bank disabled");

   a_ram_select: assert property (@(posedge CLK) disable iff (RST)
      (CPU_REQ && win != WIN_DIRECT) |=> (CPU_ACK != EXT_REQ) &&
         (CPU_ACK == $past(win_bank[RAM_SEL_BIT])))
      else $error("bit 15 did not steer ram against external");

   a_direct_ram: assert property (@(posedge CLK) disable iff (RST)
      (CPU_REQ && CPU_ADDR >= ZP_START && CPU_ADDR <= STACK_END) |=> CPU_ACK && !EXT_REQ)
      else $error("zero page or stack not served by internal ram");

   a_lcd_fetch: assert property (@(posedge CLK) disable iff (RST)
      LCD_REQ |-> ##2 LCD_VALID)
      else $error("display fetch not answered in two cycles");

   a_fb_wrap: assert property (@(posedge CLK) disable iff (RST)
      (LCD_REQ && fb_ptr_q >= fb_end_q) |=> fb_ptr_q == FB_START[14:0])
      else $error("frame pointer did not wrap at extent");
endmodule // bank_map

// ===== tb/cpu_model.sv
// CPU core model that issues byte accesses and interrupt events to the bank mapper.
`timescale 1ns/1ps
module cpu_model (
   input wire logic clk,
   output logic req,
   output logic we,
   output logic [15:0] addr,
   output logic [7:0] wdata,
   output logic int_take,
   output logic rti_done
);
   initial begin
      req = 1'b0;
      we = 1'b0;
      addr = 16'h0000;
      wdata = 8'h00;
      int_take = 1'b0;
      rti_done = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Every access is one plain read or write, never a read-modify-write.
   // Address and data are inverted once released so a stale value cannot match by luck.
   task automatic access(input logic w, input logic [15:0] a, input logic [7:0] d);
      req <= 1'b1;
      we <= w;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      req <= 1'b0;
      addr <= ~a;
      wdata <= ~d;
   endtask
   // Pulses the interrupt take when take is set, else the return from interrupt.
   task automatic pulse(input logic take);
      int_take <= take;
      rti_done <= !take;
      @(posedge clk);
      int_take <= 1'b0;
      rti_done <= 1'b0;
   endtask
endmodule // cpu_model

// ===== tb/bank_map_test.sv
// Self-checking testbench of the bank mapper.
`timescale 1ns/1ps
module bank_map_test;
   import bank_map_pkg::*;
   logic CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, CPU_REQ, CPU_WE, INT_TAKE;
   logic RTI_DONE, CPU_ACK, EXT_REQ, EXT_WE, IBANK_ACTIVE, LCD_REQ, LCD_VALID, err;
   logic [11:0] PADDR;
   logic [31:0] PWDATA, PRDATA, rd;
   logic [3:0] PSTRB;
   logic [15:0] CPU_ADDR;
   logic [7:0] CPU_WDATA, CPU_RDATA, EXT_WDATA, LCD_DATA, q;
   logic [26:0] EXT_ADDR;
   logic [15:0] wa [5] = '{16'h0085, 16'h01F0, 16'h0200, 16'h0201, 16'h2010};
   logic [15:0] ra [5] = '{16'h0085, 16'h01F0, 16'h0200, 16'h0201, 16'hA010};
   int bad_count = 0;
   int cmp_count = 0;
   bank_map i_bank_map (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA),
      .PREADY(PREADY), .PSLVERR(PSLVERR), .CPU_REQ(CPU_REQ), .CPU_WE(CPU_WE),
      .CPU_ADDR(CPU_ADDR), .CPU_WDATA(CPU_WDATA), .INT_TAKE(INT_TAKE), .RTI_DONE(RTI_DONE),
      .CPU_RDATA(CPU_RDATA), .CPU_ACK(CPU_ACK), .EXT_REQ(EXT_REQ), .EXT_WE(EXT_WE),
      .EXT_ADDR(EXT_ADDR), .EXT_WDATA(EXT_WDATA), .IBANK_ACTIVE(IBANK_ACTIVE),
      .LCD_REQ(LCD_REQ), .LCD_DATA(LCD_DATA), .LCD_VALID(LCD_VALID));
   cpu_model i_cpu_model (.clk(CLK), .req(CPU_REQ), .we(CPU_WE), .addr(CPU_ADDR),
      .wdata(CPU_WDATA), .int_take(INT_TAKE), .rti_done(RTI_DONE));
   initial begin
      CLK = 1'b0;
      forever #5 CLK = ~CLK;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // One APB transfer, entered just after a rising edge; one idle edge follows its end.
   // Only the watchdog limits the wait for ready, the slave sets the pace.
   task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] wd);
      PSEL <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE <= w;
      PADDR <= {idx, 2'b00};
      PWDATA <= wd;
      @(posedge CLK);
      PENABLE <= 1'b1;
      do begin
         @(posedge CLK);
      end while (PREADY !== 1'b1);
      rd = PRDATA;
      err = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      @(posedge CLK);
   endtask
   task automatic reg_rd(input logic [9:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 32'h0000_0000);
      chk(rd, exp);
      chk(err, 32'h0000_0000);
   endtask
   // Checks where the access went, then returns the internal read data two cycles on.
   task automatic cpu(input logic w, input logic [15:0] a, input logic [7:0] d,
         input logic ext, input logic [26:0] ea, output logic [7:0] qd);
      i_cpu_model.access(w, a, d);
      #1;
      chk(CPU_ACK, !ext);
      chk(EXT_REQ, ext);
      if (ext) begin
         chk(EXT_ADDR, ea);
      end
      @(posedge CLK);
      #1;
      qd = CPU_RDATA;
      @(posedge CLK);
   endtask
   task automatic irq(input logic take, input logic exp);
      i_cpu_model.pulse(take);
      #1;
      chk(IBANK_ACTIVE, exp);
      @(posedge CLK);
   endtask
   task automatic lcd(input logic [7:0] exp);
      LCD_REQ <= 1'b1;
      @(posedge CLK);
      LCD_REQ <= 1'b0;
      @(posedge CLK);
      #1;
      chk(LCD_VALID, 32'h0000_0001);
      chk(LCD_DATA, exp);
      @(posedge CLK);
      #1;
      @(posedge CLK);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      RST = 1'b1;
      {PSEL, PENABLE, PWRITE, LCD_REQ} = 4'h0;
      PADDR = 12'h000;
      PWDATA = 32'h0000_0000;
      PSTRB = 4'hF;
      repeat (2) @(posedge CLK);
      RST <= 1'b0;
      @(posedge CLK);
      reg_rd(IDX_IBANK_LO, 32'h0000_0000);
      reg_rd(IDX_IBANK_HI, 32'h0000_0000);
      reg_rd(IDX_SYSCTL, 32'h0000_0001);
      reg_rd(IDX_FB_END, 32'h0000_7FFF);
      apb(1'b0, 10'h3FF, 32'h0000_0000);
      chk(err, 32'h0000_0001);
      apb(1'b1, IDX_IBANK_HI, 32'h0000_00FF);
      reg_rd(IDX_IBANK_HI, 32'h0000_008F);
      apb(1'b1, IDX_IBANK_LO, 32'h0000_0056);
      apb(1'b1, IDX_IBANK_HI, 32'h0000_0004);
      apb(1'b1, IDX_PBANK, 32'h0000_0123);
      // With the enable bit clear, a taken interrupt keeps the program bank.
      irq(1'b1, 1'b0);
      cpu(1'b0, 16'h7FFE, 8'h00, 1'b1, {12'h123, 15'h7FFE}, q);
      apb(1'b1, IDX_SYSCTL, 32'h0000_0002);
      reg_rd(IDX_SYSCTL, 32'h0000_0003);
      irq(1'b1, 1'b1);
      cpu(1'b0, 16'h7FFE, 8'h00, 1'b1, {12'h456, 15'h7FFE}, q);
      reg_rd(IDX_STATUS, 32'h0001_0456);
      cpu(1'b0, 16'h4010, 8'h00, 1'b1, {12'h456, 15'h4010}, q);
      irq(1'b0, 1'b0);
      cpu(1'b0, 16'h4010, 8'h00, 1'b1, {12'h123, 15'h4010}, q);
      // An external write must carry its direction and data out with the address.
      cpu(1'b1, 16'h4020, 8'hA5, 1'b1, {12'h123, 15'h4020}, q);
      chk(EXT_WE, 32'h0000_0001);
      chk(EXT_WDATA, 32'h0000_00A5);
      apb(1'b1, IDX_SBANK, 32'h0000_8000);
      apb(1'b1, IDX_DBANK, 32'h0000_8000);
      apb(1'b1, IDX_FB_END, 32'h0000_0201);
      // The last pair writes through the secondary window and reads back through data.
      for (int i = 0; i < 5; i++) begin
         cpu(1'b1, wa[i], 8'h31 + 8'(i), 1'b0, 27'h0, q);
      end
      for (int i = 0; i < 5; i++) begin
         cpu(1'b0, ra[i], 8'h00, 1'b0, 27'h0, q);
         chk(q, 8'h31 + 8'(i));
      end
      // The display fetch runs beside a CPU read that must not be held off.
      fork
         lcd(8'h33);
         cpu(1'b0, 16'h0085, 8'h00, 1'b0, 27'h0, q);
      join
      chk(q, 8'h31);
      lcd(8'h34);
      lcd(8'h33);
      summarize();
   end
   initial begin
      #20000;
      bad_count++;
      summarize();
   end
endmodule // bank_map_test
